// ==== logic/rdi_map.svh ====
// constants for the transceiver direction and interrupt mode block
`ifndef RDI_MAP_SVH
`define RDI_MAP_SVH
`define RDI_FIFO_DEPTH 16
`define RDI_DIV_W 16
`define RDI_CHAR_W 8
`define RDI_NPORT 2
`define RDI_MIN_BITS 3'h4
`define RDI_LINE_IDLE 1'b1
`endif

// ==== logic/rdi_pkg.sv ====
// types for the transceiver direction and interrupt mode block
`include "rdi_map.svh"
`default_nettype none
package rdi_pkg;
	typedef enum logic {drv_rts, drv_auto} rdi_drv_sel_t;
	typedef struct packed {
		logic multidrop;
		logic no_echo;
	} rdi_echo_sel_t;
	typedef enum logic [1:0] {
		irq_normal,
		irq_shared,
		irq_shared_pd,
		irq_off
	} rdi_irq_mode_t;
	typedef struct packed {
		logic [`RDI_DIV_W-1:0] divisor;
		logic [1:0]            data_len;
		logic                  par_en;
		logic                  par_even;
		logic                  two_stop;
		logic                  rts;
		logic                  ie_rx;
		logic                  ie_tx;
	} rdi_uart_cfg_t;
	typedef struct packed {
		logic                   par_err;
		logic                   frame_err;
		logic [`RDI_CHAR_W-1:0] data;
	} rdi_rx_char_t;
	typedef enum logic [2:0] {
		tx_idle, tx_start, tx_data, tx_par, tx_stop
	} rdi_tx_state_t;
	typedef enum logic [2:0] {
		rx_idle, rx_start, rx_data, rx_par, rx_stop
	} rdi_rx_state_t;
endpackage
`default_nettype wire

// ==== logic/rdi_top.sv ====
// two serial ports with line driver direction and interrupt mode logic
`include "rdi_map.svh"
`default_nettype none
module rdi_top #(
	parameter int FIFO_DEPTH = `RDI_FIFO_DEPTH
) (
	input  wire logic                                     sys_clk,
	input  wire logic                                     rst_b,
	input  wire rdi_pkg::rdi_drv_sel_t                    port1_driver_enable_select,
	input  wire rdi_pkg::rdi_drv_sel_t                    port2_driver_enable_select,
	input  wire rdi_pkg::rdi_echo_sel_t                   port1_echo_driver_select,
	input  wire rdi_pkg::rdi_echo_sel_t                   port2_echo_driver_select,
	input  wire rdi_pkg::rdi_irq_mode_t                   port1_irq_mode_select,
	input  wire rdi_pkg::rdi_irq_mode_t                   port2_irq_mode_select,
	input  wire logic [`RDI_NPORT-1:0]                    rts_route_fitted,
	input  wire rdi_pkg::rdi_uart_cfg_t [`RDI_NPORT-1:0]  uart_cfg,
	input  wire logic [`RDI_NPORT-1:0]                    tx_valid,
	input  wire logic [`RDI_NPORT-1:0][`RDI_CHAR_W-1:0]   tx_data,
	output logic [`RDI_NPORT-1:0]                         tx_ready,
	output logic [`RDI_NPORT-1:0]                         rx_valid,
	output rdi_pkg::rdi_rx_char_t [`RDI_NPORT-1:0]        rx_data,
	input  wire logic [`RDI_NPORT-1:0]                    rx_ready,
	output logic [`RDI_NPORT-1:0]                         rx_overrun,
	input  wire logic [`RDI_NPORT-1:0]                    line_rx,
	output logic [`RDI_NPORT-1:0]                         line_tx_out,
	output logic [`RDI_NPORT-1:0]                         line_tx_oe,
	output logic [`RDI_NPORT-1:0]                         rcv_en,
	output logic [`RDI_NPORT-1:0]                         rts_line_out,
	output logic [`RDI_NPORT-1:0]                         rts_line_oe,
	output logic [`RDI_NPORT-1:0]                         irq_out,
	output logic [`RDI_NPORT-1:0]                         irq_oe,
	output logic [`RDI_NPORT-1:0]                         irq_pulldown_en
);
	localparam int AW = $clog2(FIFO_DEPTH);

	if (FIFO_DEPTH < 2 || (1 << AW) != FIFO_DEPTH) begin : g_bad_depth
		$error("FIFO_DEPTH must be a power of two of at least 2");
	end

	function automatic logic ptr_full(input logic [AW:0] w, input logic [AW:0] r);
		return (w[AW] != r[AW]) && (w[AW-1:0] == r[AW-1:0]);
	endfunction

	// a divisor of zero would wrap to 65536 clocks per tick, so it is served as one
	function automatic logic [`RDI_DIV_W-1:0] div_m1(
		input logic [`RDI_DIV_W-1:0] div);
		return (div == '0) ? '0 : div - 16'h0001;
	endfunction

	logic rst_n_q1;
	logic rst_n;
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			rst_n_q1 <= 1'b0;
			rst_n    <= 1'b0;
		end else begin
			rst_n_q1 <= 1'b1;
			rst_n    <= rst_n_q1;
		end
	end

	wire rdi_pkg::rdi_drv_sel_t  drv_sel_in [`RDI_NPORT];
	wire rdi_pkg::rdi_echo_sel_t echo_in    [`RDI_NPORT];
	wire rdi_pkg::rdi_irq_mode_t irq_in     [`RDI_NPORT];
	assign drv_sel_in[0] = port1_driver_enable_select;
	assign drv_sel_in[1] = port2_driver_enable_select;
	assign echo_in[0]    = port1_echo_driver_select;
	assign echo_in[1]    = port2_echo_driver_select;
	assign irq_in[0]     = port1_irq_mode_select;
	assign irq_in[1]     = port2_irq_mode_select;

	for (genvar p = 0; p < `RDI_NPORT; p++) begin : g_port
		rdi_pkg::rdi_drv_sel_t  drv_sel_q;
		rdi_pkg::rdi_echo_sel_t echo_q;
		rdi_pkg::rdi_irq_mode_t irq_mode_q;
		logic                   route_q;
		rdi_pkg::rdi_uart_cfg_t cfg;
		assign cfg = uart_cfg[p];

		// straps are caught every clock; they are static in practice
		always_ff @(posedge sys_clk or negedge rst_n) begin
			if (!rst_n) begin
				drv_sel_q  <= rdi_pkg::drv_auto;
				echo_q     <= '0;
				irq_mode_q <= rdi_pkg::irq_off;
				route_q    <= 1'b0;
			end else begin
				drv_sel_q  <= drv_sel_in[p];
				echo_q     <= echo_in[p];
				irq_mode_q <= irq_in[p];
				route_q    <= rts_route_fitted[p];
			end
		end

		// transmit fifo
		logic [`RDI_CHAR_W-1:0] txm [FIFO_DEPTH];
		logic [AW:0]            txw_q;
		logic [AW:0]            txr_q;
		logic                   tx_pop;
		wire                    tx_empty = (txw_q == txr_q);
		wire                    tx_push = tx_valid[p] && tx_ready[p];
		assign tx_ready[p] = !ptr_full(txw_q, txr_q);
		always_ff @(posedge sys_clk) begin
			if (tx_push) begin
				txm[txw_q[AW-1:0]] <= tx_data[p];
			end
		end

		// transmit shifter
		rdi_pkg::rdi_tx_state_t tx_state_q, tx_state_d;
		logic [`RDI_DIV_W-1:0]  tx_cnt_q, tx_cnt_d;
		logic [2:0]             tx_bit_q, tx_bit_d;
		logic [`RDI_CHAR_W-1:0] tx_sh_q, tx_sh_d;
		logic                   tx_line_q, tx_line_d;
		logic                   tx_par_q, tx_par_d;
		logic                   tx_stop2_q, tx_stop2_d;
		wire                    tx_tick = (tx_cnt_q == '0);
		wire [2:0]              last_bit = {1'b0, cfg.data_len} + `RDI_MIN_BITS;

		always_comb begin
			tx_state_d = tx_state_q;
			tx_cnt_d   = tx_tick ? div_m1(cfg.divisor) : tx_cnt_q - 16'h0001;
			tx_bit_d   = tx_bit_q;
			tx_sh_d    = tx_sh_q;
			tx_line_d  = tx_line_q;
			tx_par_d   = tx_par_q;
			tx_stop2_d = tx_stop2_q;
			tx_pop     = 1'b0;
			unique case (tx_state_q)
				rdi_pkg::tx_idle: begin
					tx_cnt_d = div_m1(cfg.divisor);
					if (!tx_empty) begin
						tx_pop     = 1'b1;
						tx_sh_d    = txm[txr_q[AW-1:0]];
						tx_par_d   = !cfg.par_even;
						tx_line_d  = 1'b0;
						tx_state_d = rdi_pkg::tx_start;
					end
				end
				rdi_pkg::tx_start: begin
					if (tx_tick) begin
						tx_line_d  = tx_sh_q[0];
						tx_par_d   = tx_par_q ^ tx_sh_q[0];
						tx_sh_d    = tx_sh_q >> 1;
						tx_bit_d   = 3'h0;
						tx_state_d = rdi_pkg::tx_data;
					end
				end
				rdi_pkg::tx_data: begin
					if (tx_tick && tx_bit_q == last_bit) begin
						tx_stop2_d = cfg.two_stop;
						if (cfg.par_en) begin
							tx_line_d  = tx_par_q;
							tx_state_d = rdi_pkg::tx_par;
						end else begin
							tx_line_d  = `RDI_LINE_IDLE;
							tx_state_d = rdi_pkg::tx_stop;
						end
					end else if (tx_tick) begin
						tx_bit_d  = tx_bit_q + 3'h1;
						tx_line_d = tx_sh_q[0];
						tx_par_d  = tx_par_q ^ tx_sh_q[0];
						tx_sh_d   = tx_sh_q >> 1;
					end
				end
				rdi_pkg::tx_par: begin
					if (tx_tick) begin
						tx_line_d  = `RDI_LINE_IDLE;
						tx_state_d = rdi_pkg::tx_stop;
					end
				end
				rdi_pkg::tx_stop: begin
					if (tx_tick && tx_stop2_q) begin
						tx_stop2_d = 1'b0;
					end else if (tx_tick) begin
						tx_state_d = rdi_pkg::tx_idle;
					end
				end
			endcase
		end

		always_ff @(posedge sys_clk or negedge rst_n) begin
			if (!rst_n) begin
				txw_q      <= '0;
				txr_q      <= '0;
				tx_state_q <= rdi_pkg::tx_idle;
				tx_cnt_q   <= '0;
				tx_bit_q   <= 3'h0;
				tx_sh_q    <= '0;
				tx_line_q  <= `RDI_LINE_IDLE;
				tx_par_q   <= 1'b0;
				tx_stop2_q <= 1'b0;
			end else begin
				txw_q      <= txw_q + (AW+1)'(tx_push);
				txr_q      <= txr_q + (AW+1)'(tx_pop);
				tx_state_q <= tx_state_d;
				tx_cnt_q   <= tx_cnt_d;
				tx_bit_q   <= tx_bit_d;
				tx_sh_q    <= tx_sh_d;
				tx_line_q  <= tx_line_d;
				tx_par_q   <= tx_par_d;
				tx_stop2_q <= tx_stop2_d;
			end
		end

		// busy from the moment data waits until the last stop bit ends
		wire tx_busy = (tx_state_q != rdi_pkg::tx_idle) || !tx_empty;
		wire drv_d = !echo_q.multidrop ? 1'b1 :
		             (drv_sel_q == rdi_pkg::drv_rts) ? cfg.rts :
		             tx_busy;
		// receiver follows drv_d so it is off in the same cycle the driver is on
		wire rcv_d = !(echo_q.multidrop && echo_q.no_echo && drv_d);
		logic drv_q;
		logic rcv_q;
		logic rts_out_q;
		logic rts_oe_q;
		always_ff @(posedge sys_clk or negedge rst_n) begin
			if (!rst_n) begin
				drv_q     <= 1'b0;
				rcv_q     <= 1'b1;
				rts_out_q <= 1'b0;
				rts_oe_q  <= 1'b0;
			end else begin
				drv_q     <= drv_d;
				rcv_q     <= rcv_d;
				rts_out_q <= cfg.rts;
				rts_oe_q  <= !echo_q.multidrop && route_q;
			end
		end
		assign line_tx_out[p]  = tx_line_q;
		assign line_tx_oe[p]   = drv_q;
		assign rcv_en[p]       = rcv_q;
		assign rts_line_out[p] = rts_out_q;
		assign rts_line_oe[p]  = rts_oe_q;

		// receive line: three stages, a change counts when stages two and three agree
		logic rx_s1_q, rx_s2_q, rx_s3_q, rx_filt_q;
		always_ff @(posedge sys_clk or negedge rst_n) begin
			if (!rst_n) begin
				rx_s1_q   <= `RDI_LINE_IDLE;
				rx_s2_q   <= `RDI_LINE_IDLE;
				rx_s3_q   <= `RDI_LINE_IDLE;
				rx_filt_q <= `RDI_LINE_IDLE;
			end else begin
				rx_s1_q   <= line_rx[p];
				rx_s2_q   <= rx_s1_q;
				rx_s3_q   <= rx_s2_q;
				rx_filt_q <= (rx_s2_q == rx_s3_q) ? rx_s3_q : rx_filt_q;
			end
		end
		// a disabled receiver reads as an idle line
		wire rx_line = rcv_q ? rx_filt_q : `RDI_LINE_IDLE;

		// receive fifo
		rdi_pkg::rdi_rx_char_t  rxm [FIFO_DEPTH];
		logic [AW:0]            rxw_q;
		logic [AW:0]            rxr_q;
		logic                   rx_push;
		wire                    rx_full = ptr_full(rxw_q, rxr_q);
		wire                    rx_pop = rx_valid[p] && rx_ready[p];
		wire                    rx_wr = rx_push && !rx_full;
		assign rx_valid[p] = (rxw_q != rxr_q);
		assign rx_data[p]  = rxm[rxr_q[AW-1:0]];

		rdi_pkg::rdi_rx_state_t rx_state_q, rx_state_d;
		logic [`RDI_DIV_W-1:0]  rx_cnt_q, rx_cnt_d;
		logic [2:0]             rx_bit_q, rx_bit_d;
		logic [`RDI_CHAR_W-1:0] rx_sh_q, rx_sh_d;
		logic                   rx_par_q, rx_par_d;
		logic                   rx_perr_q, rx_perr_d;
		wire                    rx_tick = (rx_cnt_q == '0);
		rdi_pkg::rdi_rx_char_t  rx_char;
		assign rx_char.par_err   = rx_perr_q;
		assign rx_char.frame_err = !rx_line;
		assign rx_char.data      = rx_sh_q >> (2'h3 - cfg.data_len);

		always_comb begin
			rx_state_d = rx_state_q;
			rx_cnt_d   = rx_tick ? div_m1(cfg.divisor) : rx_cnt_q - 16'h0001;
			rx_bit_d   = rx_bit_q;
			rx_sh_d    = rx_sh_q;
			rx_par_d   = rx_par_q;
			rx_perr_d  = rx_perr_q;
			rx_push    = 1'b0;
			unique case (rx_state_q)
				rdi_pkg::rx_idle: begin
					rx_cnt_d = div_m1(cfg.divisor) >> 1;
					if (!rx_line) begin
						rx_state_d = rdi_pkg::rx_start;
					end
				end
				rdi_pkg::rx_start: begin
					if (rx_tick && rx_line) begin
						rx_state_d = rdi_pkg::rx_idle;
					end else if (rx_tick) begin
						rx_bit_d   = 3'h0;
						rx_par_d   = !cfg.par_even;
						rx_perr_d  = 1'b0;
						rx_state_d = rdi_pkg::rx_data;
					end
				end
				rdi_pkg::rx_data: begin
					if (rx_tick) begin
						rx_sh_d  = {rx_line, rx_sh_q[`RDI_CHAR_W-1:1]};
						rx_par_d = rx_par_q ^ rx_line;
						rx_bit_d = rx_bit_q + 3'h1;
						if (rx_bit_q == last_bit) begin
							rx_state_d = cfg.par_en ? rdi_pkg::rx_par
							                        : rdi_pkg::rx_stop;
						end
					end
				end
				rdi_pkg::rx_par: begin
					if (rx_tick) begin
						rx_perr_d  = (rx_line != rx_par_q);
						rx_state_d = rdi_pkg::rx_stop;
					end
				end
				rdi_pkg::rx_stop: begin
					if (rx_tick) begin
						rx_push    = 1'b1;
						rx_state_d = rdi_pkg::rx_idle;
					end
				end
			endcase
		end

		always_ff @(posedge sys_clk) begin
			if (rx_wr) begin
				rxm[rxw_q[AW-1:0]] <= rx_char;
			end
		end

		logic ovr_q;
		always_ff @(posedge sys_clk or negedge rst_n) begin
			if (!rst_n) begin
				rxw_q      <= '0;
				rxr_q      <= '0;
				rx_state_q <= rdi_pkg::rx_idle;
				rx_cnt_q   <= '0;
				rx_bit_q   <= 3'h0;
				rx_sh_q    <= '0;
				rx_par_q   <= 1'b0;
				rx_perr_q  <= 1'b0;
				ovr_q      <= 1'b0;
			end else begin
				rxw_q      <= rxw_q + (AW+1)'(rx_wr);
				rxr_q      <= rxr_q + (AW+1)'(rx_pop);
				rx_state_q <= rx_state_d;
				rx_cnt_q   <= rx_cnt_d;
				rx_bit_q   <= rx_bit_d;
				rx_sh_q    <= rx_sh_d;
				rx_par_q   <= rx_par_d;
				rx_perr_q  <= rx_perr_d;
				ovr_q      <= rx_push && rx_full;
			end
		end
		assign rx_overrun[p] = ovr_q;

		// interrupt request and its line drive per mode
		wire irq_req = (cfg.ie_rx && rx_valid[p]) || (cfg.ie_tx && !tx_busy);
		wire shared = (irq_mode_q == rdi_pkg::irq_shared) ||
		              (irq_mode_q == rdi_pkg::irq_shared_pd);
		logic irq_out_q;
		logic irq_oe_q;
		logic pd_q;
		always_ff @(posedge sys_clk or negedge rst_n) begin
			if (!rst_n) begin
				irq_out_q <= 1'b0;
				irq_oe_q  <= 1'b0;
				pd_q      <= 1'b0;
			end else begin
				irq_out_q <= shared ? 1'b1 : irq_req;
				irq_oe_q  <= (irq_mode_q == rdi_pkg::irq_normal) ||
				             (shared && irq_req);
				// only one port on a shared line may set this
				pd_q      <= (irq_mode_q == rdi_pkg::irq_shared_pd);
			end
		end
		assign irq_out[p]         = irq_out_q;
		assign irq_oe[p]          = irq_oe_q;
		assign irq_pulldown_en[p] = pd_q;
	end
endmodule
`default_nettype wire

// ==== testbench/rdi_far_end.sv ====
// remote serial node on the cable: 8N1 receiver and sender
`default_nettype none
module rdi_far_end #(
	parameter int BIT = 4
) (
	input  wire logic       sys_clk,
	input  wire logic       line_tx_out,
	input  wire logic       line_tx_oe,
	output logic            far_d,
	output logic            far_oe,
	output logic [7:0]      got_byte,
	output logic [7:0]      got_n
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [7:0] b;
	initial begin
		far_d = 1'b1;
		far_oe = 1'b0;
		got_byte = 8'h00;
		got_n = 8'h00;
	end
	// only frames with the driver on count; a floating line is not data
	always begin
		@(negedge line_tx_out);
		// enable and start bit switch on the same edge; let both settle
		#1;
		if (line_tx_oe) begin
			repeat (BIT / 2) @(posedge sys_clk);
			for (int i = 0; i < 8; i++) begin
				repeat (BIT) @(posedge sys_clk);
				b[i] = line_tx_out;
			end
			repeat (BIT) @(posedge sys_clk);
			if (line_tx_out) begin
				got_byte = b;
				got_n = got_n + 8'h01;
			end
		end
	end
	task automatic send(input logic [7:0] v);
		logic [9:0] f;
		f = {1'b1, v, 1'b0};
		while (line_tx_oe) @(posedge sys_clk);
		for (int i = 0; i < 10; i++) begin
			@(posedge sys_clk);
			#1 far_d = f[i];
			far_oe = 1'b1;
			repeat (BIT - 1) @(posedge sys_clk);
		end
		@(posedge sys_clk);
		#1 far_oe = 1'b0;
	endtask
endmodule
`default_nettype wire

// ==== testbench/rdi_top_bench.sv ====
// self-checking bench for the two-port direction and interrupt logic
`default_nettype none
module rdi_top_bench;
	timeunit 1ns;
	timeprecision 100ps;
	logic                          sys_clk = 1'b0;
	logic                          rst_b = 1'b0;
	rdi_pkg::rdi_drv_sel_t         ds [2];
	rdi_pkg::rdi_echo_sel_t        es [2];
	rdi_pkg::rdi_irq_mode_t        ms [2];
	rdi_pkg::rdi_uart_cfg_t [1:0]  cfg;
	rdi_pkg::rdi_rx_char_t [1:0]   rx_data;
	logic [1:0][7:0]               tx_data, far_b, far_n;
	logic [1:0]                    fit, tx_valid, tx_ready, rx_valid, rx_ready;
	logic [1:0]                    rx_overrun, line_rx, line_tx_out, line_tx_oe;
	logic [1:0]                    rcv_en, rts_line_out, rts_line_oe, irq_out;
	logic [1:0]                    irq_oe, irq_pulldown_en, far_d, far_oe;
	int                            failures, check_count, acc, n, m;
	int                            seed = 60;
	int                            ovr [2] = '{0, 0};
	logic [31:0]                   r;
	logic [7:0]                    b0, b1, first;
	always #50 sys_clk = ~sys_clk;
	// two-wire bus with receive bias: low if any driver pulls low
	assign line_rx = ~rcv_en | ~({es[1].multidrop, es[0].multidrop} &
		line_tx_oe & ~line_tx_out) & ~(far_oe & ~far_d);
	rdi_top DUT (.sys_clk(sys_clk), .rst_b(rst_b),
		.port1_driver_enable_select(ds[0]), .port2_driver_enable_select(ds[1]),
		.port1_echo_driver_select(es[0]), .port2_echo_driver_select(es[1]),
		.port1_irq_mode_select(ms[0]), .port2_irq_mode_select(ms[1]),
		.rts_route_fitted(fit), .uart_cfg(cfg), .tx_valid(tx_valid),
		.tx_data(tx_data), .tx_ready(tx_ready), .rx_valid(rx_valid),
		.rx_data(rx_data), .rx_ready(rx_ready), .rx_overrun(rx_overrun),
		.line_rx(line_rx), .line_tx_out(line_tx_out), .line_tx_oe(line_tx_oe),
		.rcv_en(rcv_en), .rts_line_out(rts_line_out), .rts_line_oe(rts_line_oe),
		.irq_out(irq_out), .irq_oe(irq_oe), .irq_pulldown_en(irq_pulldown_en));
	rdi_far_end #(.BIT(4)) far [1:0] (.sys_clk(sys_clk),
		.line_tx_out(line_tx_out), .line_tx_oe(line_tx_oe), .far_d(far_d),
		.far_oe(far_oe), .got_byte(far_b), .got_n(far_n));
	always @(posedge sys_clk)
		for (int p = 0; p < 2; p++)
			if (rx_overrun[p] === 1'b1)
				ovr[p] = ovr[p] + 1;
	task automatic tick(input int k);
		repeat (k) @(posedge sys_clk);
		#1;
	endtask
	task automatic check(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			failures++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic end_of_test();
		$display("checks %0d failures %0d", check_count, failures);
		if (failures == 0 && check_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic do_reset();
		rst_b = 1'b0;
		tick(4);
		check("reset pins", {line_tx_oe, rcv_en, tx_ready, rx_valid, irq_oe},
			10'h0f0);
		rst_b = 1'b1;
		tick(4);
	endtask
	// pushes back to back until refused or k bytes taken
	task automatic fill(input int p, input int k, input logic [7:0] v,
		output int got);
		logic ok;
		got = 0;
		tx_valid[p] = 1'b1;
		tx_data[p] = v;
		do begin
			ok = tx_ready[p];
			tick(1);
			if (ok)
				got++;
			tx_data[p] = 8'(v + got);
		end while (ok && got < k);
		tx_valid[p] = 1'b0;
	endtask
	task automatic drain(input int p, output int got, output logic [7:0] f);
		logic ok;
		got = 0;
		rx_ready[p] = 1'b1;
		do begin
			ok = rx_valid[p];
			if (ok && got == 0)
				f = rx_data[p].data;
			tick(1);
			if (ok)
				got++;
		end while (ok && got < 20);
		rx_ready[p] = 1'b0;
	endtask
	function automatic logic [5:0] want(input int p);
		logic oe, sh, nm;
		oe = !es[p].multidrop || (ds[p] == rdi_pkg::drv_rts && cfg[p].rts);
		sh = ms[p] == rdi_pkg::irq_shared || ms[p] == rdi_pkg::irq_shared_pd;
		nm = ms[p] == rdi_pkg::irq_normal;
		return {oe, !(es[p].multidrop && es[p].no_echo && oe),
			!es[p].multidrop && fit[p], cfg[p].ie_tx || sh,
			nm || (sh && cfg[p].ie_tx), ms[p] == rdi_pkg::irq_shared_pd};
	endfunction
	// only the low data_len+5 bits of a character travel
	function automatic logic [7:0] low_bits(input logic [7:0] v,
		input logic [1:0] len);
		logic [7:0] m;
		m = '0;
		for (int i = 0; i < int'(len) + 5; i++)
			m[i] = v[i];
		return m;
	endfunction
	initial begin
		repeat (30000) @(posedge sys_clk);
		failures++;
		end_of_test();
	end
	initial begin
		{fit, tx_valid, rx_ready, tx_data, cfg} = '0;
		for (int p = 0; p < 2; p++) begin
			es[p] = 2'b00;
			ds[p] = rdi_pkg::drv_rts;
			ms[p] = rdi_pkg::irq_off;
			cfg[p].divisor = 16'h0004;
			cfg[p].data_len = 2'h3;
		end
		do_reset();
		for (int i = 0; i < 40; i++) begin
			for (int p = 0; p < 2; p++) begin
				r = $random(seed);
				es[p] = r[1:0];
				ds[p] = rdi_pkg::rdi_drv_sel_t'(r[2]);
				ms[p] = rdi_pkg::rdi_irq_mode_t'(r[4:3]);
				{fit[p], cfg[p].rts, cfg[p].ie_tx, cfg[p].ie_rx} = r[8:5];
			end
			if (ms[0] == rdi_pkg::irq_shared_pd && ms[1] == ms[0])
				ms[1] = rdi_pkg::irq_shared;
			tick(2);
			for (int p = 0; p < 2; p++)
				check("pins", {line_tx_oe[p], rcv_en[p], rts_line_oe[p], irq_out[p], irq_oe[p], irq_pulldown_en[p]}, want(p));
		end
		do_reset();
		for (int p = 0; p < 2; p++) begin
			es[p] = 2'b10;
			ds[p] = rdi_pkg::drv_auto;
			ms[p] = rdi_pkg::irq_normal;
			{cfg[p].ie_tx, cfg[p].ie_rx} = 2'b10;
			tick(3);
			check("irq idle", irq_out[p], 1'b1);
			r = $random(seed);
			b0 = r[7:0];
			b1 = ~b0;
			n = ovr[p];
			m = far_n[p] + acc * 0;
			fill(p, 20, b0, acc);
			check("irq busy", irq_out[p], 1'b0);
			check("accepted", acc inside {16, 17}, 1'b1);
			m = m + acc;
			for (int k = 0; k < 3000 && far_n[p] !== 8'(m); k++) tick(1);
			check("far count", far_n[p], 8'(m));
			check("far byte", far_b[p], 8'(b0 + acc - 1));
			tick(8);
			check("overrun", ovr[p] - n, acc - 16);
			check("oe idle", line_tx_oe[p], 1'b0);
			drain(p, n, first);
			check("rx count", n, 16);
			check("echo", first, b0);
			es[p].no_echo = 1'b1;
			m = far_n[p] + 1;
			fill(p, 1, b1, acc);
			for (int k = 0; k < 200 && far_n[p] !== 8'(m); k++) tick(1);
			tick(8);
			check("far byte", far_b[p], b1);
			check("no echo", rx_valid[p], 1'b0);
		end
		es[0] = 2'b10;
		ds[0] = rdi_pkg::drv_rts;
		{cfg[0].rts, cfg[0].ie_rx, cfg[0].ie_tx} = 3'b010;
		tick(3);
		r = $random(seed);
		far[0].send(r[7:0]);
		for (int k = 0; k < 50 && rx_valid[0] !== 1'b1; k++) tick(1);
		tick(2);
		check("rx char", rx_data[0], {2'b00, r[7:0]});
		check("irq rx", irq_out[0], 1'b1);
		// echo loopback with parity, two stops and a random length
		es[1] = 2'b10;
		r = $random(seed);
		{cfg[1].par_en, cfg[1].par_even, cfg[1].two_stop} = {1'b1, r[10], 1'b1};
		cfg[1].data_len = r[9:8];
		fill(1, 1, r[7:0], acc);
		for (int k = 0; k < 150 && rx_valid[1] !== 1'b1; k++) tick(1);
		check("loop char", rx_data[1], {2'b00, low_bits(r[7:0], r[9:8])});
		end_of_test();
	end
endmodule
`default_nettype wire

// ==== testbench/rdi_top_sva.sv ====
// concurrent checks on the driver direction and interrupt mode pins
`include "rdi_map.svh"
`default_nettype none
module rdi_top_sva (
	input wire logic                                    sys_clk,
	input wire logic                                    rst_b,
	input wire rdi_pkg::rdi_drv_sel_t                   port1_driver_enable_select,
	input wire rdi_pkg::rdi_drv_sel_t                   port2_driver_enable_select,
	input wire rdi_pkg::rdi_echo_sel_t                  port1_echo_driver_select,
	input wire rdi_pkg::rdi_echo_sel_t                  port2_echo_driver_select,
	input wire rdi_pkg::rdi_irq_mode_t                  port1_irq_mode_select,
	input wire rdi_pkg::rdi_irq_mode_t                  port2_irq_mode_select,
	input wire logic [`RDI_NPORT-1:0]                   rts_route_fitted,
	input wire rdi_pkg::rdi_uart_cfg_t [`RDI_NPORT-1:0] uart_cfg,
	input wire logic [`RDI_NPORT-1:0]                   tx_valid,
	input wire logic [`RDI_NPORT-1:0]                   tx_ready,
	input wire logic [`RDI_NPORT-1:0]                   rx_valid,
	input wire logic [`RDI_NPORT-1:0]                   line_tx_out,
	input wire logic [`RDI_NPORT-1:0]                   line_tx_oe,
	input wire logic [`RDI_NPORT-1:0]                   rcv_en,
	input wire logic [`RDI_NPORT-1:0]                   rts_line_out,
	input wire logic [`RDI_NPORT-1:0]                   rts_line_oe,
	input wire logic [`RDI_NPORT-1:0]                   irq_out,
	input wire logic [`RDI_NPORT-1:0]                   irq_oe,
	input wire logic [`RDI_NPORT-1:0]                   irq_pulldown_en
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [1:0]             md, ne, au, rt;
	rdi_pkg::rdi_irq_mode_t im [2];
	logic [2:0]             cnt_q;
	logic                   live;
	assign md = {port2_echo_driver_select.multidrop,
		port1_echo_driver_select.multidrop};
	assign ne = {port2_echo_driver_select.no_echo,
		port1_echo_driver_select.no_echo};
	assign au = {port2_driver_enable_select == rdi_pkg::drv_auto,
		port1_driver_enable_select == rdi_pkg::drv_auto};
	assign rt = {uart_cfg[1].rts, uart_cfg[0].rts};
	assign im[0] = port1_irq_mode_select;
	assign im[1] = port2_irq_mode_select;
	// the internal reset copy lags rst_b, so checks wait a few edges
	always_ff @(posedge sys_clk or negedge rst_b)
		if (!rst_b)
			cnt_q <= 3'h0;
		else if (cnt_q != 3'h5)
			cnt_q <= cnt_q + 3'h1;
	assign live = cnt_q == 3'h5;
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!rst_b || !live);
	for (genvar p = 0; p < 2; p++) begin : g_port
		a_p2p_drive_on: assert property ($past(!md[p], 2) |-> line_tx_oe[p])
			else $error("driver off in point-to-point");
		a_rts_drive_src: assert property ($past(md[p] && !au[p], 2) |->
			line_tx_oe[p] == $past(rt[p]))
			else $error("driver does not follow rts");
		a_auto_drive_on: assert property (md[p] && au[p] && tx_valid[p] &&
			tx_ready[p] |-> ##[1:3] line_tx_oe[p])
			else $error("auto driver not on after queued byte");
		a_auto_start_drives: assert property (md[p] && au[p] &&
			$fell(line_tx_out[p]) |-> line_tx_oe[p])
			else $error("start bit sent with driver off");
		a_auto_release_idle: assert property ($past(md[p] && au[p]) &&
			$fell(line_tx_oe[p]) |-> line_tx_out[p] && tx_ready[p])
			else $error("auto driver released mid character");
		a_rts_shown: assert property ($past(!md[p] && rts_route_fitted[p], 2) |->
			rts_line_oe[p] && rts_line_out[p] == $past(rt[p]))
			else $error("rts missing on connector");
		a_rts_hidden: assert property ($past(md[p] || !rts_route_fitted[p], 2) |->
			!rts_line_oe[p])
			else $error("rts shown on connector");
		a_echo_rx_on: assert property ($past(!(md[p] && ne[p]), 2) |-> rcv_en[p])
			else $error("receiver off in echo mode");
		a_noecho_rx_off: assert property ($past(md[p] && ne[p], 2) |->
			rcv_en[p] == !line_tx_oe[p])
			else $error("receiver state wrong in no-echo mode");
		a_irq_normal_drive: assert property ($past(im[p] == rdi_pkg::irq_normal, 2)
			|-> irq_oe[p])
			else $error("normal request line not driven");
		a_irq_shared_level: assert property ($past(im[p] == rdi_pkg::irq_shared
			|| im[p] == rdi_pkg::irq_shared_pd, 2) |-> irq_out[p])
			else $error("shared request line drives inactive level");
		a_irq_pulldown_sel: assert property (irq_pulldown_en[p] ==
			$past(im[p] == rdi_pkg::irq_shared_pd, 2))
			else $error("pull-down select wrong");
		c_auto_on: cover property (md[p] && au[p] && $rose(line_tx_oe[p]));
		c_rx_char: cover property ($rose(rx_valid[p]));
		c_pulldown: cover property (irq_pulldown_en[p] && irq_oe[p]);
	end
endmodule
bind rdi_top rdi_top_sva chk (.sys_clk, .rst_b, .port1_driver_enable_select,
	.port2_driver_enable_select, .port1_echo_driver_select,
	.port2_echo_driver_select, .port1_irq_mode_select, .port2_irq_mode_select,
	.rts_route_fitted, .uart_cfg, .tx_valid, .tx_ready, .rx_valid, .line_tx_out,
	.line_tx_oe, .rcv_en, .rts_line_out, .rts_line_oe, .irq_out, .irq_oe,
	.irq_pulldown_en);
`default_nettype wire
